// file: usbd_pkg.sv
// Shared constants for the USB state/DMA device end and its bus controller.
// Assumes both ends run on one 20 MHz clock and share this package.
package usbd_pkg;
  // Device register offsets on the 8-bit register port
  localparam logic [7:0] REG_GS = 8'he6;
  localparam logic [7:0] REG_FA = 8'he7;
  localparam logic [7:0] REG_FNL = 8'he8;
  localparam logic [7:0] REG_FNH = 8'he9;
  localparam logic [7:0] REG_DCS = 8'hea;
  localparam logic [7:0] REG_DAL = 8'heb;
  localparam logic [7:0] REG_DAH = 8'hec;
  localparam logic [7:0] REG_DBC = 8'hed;
  // Field positions
  localparam int GS_RSM = 3;
  localparam int GS_RWE = 2;
  localparam int GS_CFG = 1;
  localparam int GS_ADR = 0;
  localparam int FNH_END = 4;
  localparam int FNH_ERR = 3;
  localparam int DCS_EPS = 4;
  localparam int DCS_ERR = 2;
  localparam int DCS_DIR = 1;
  localparam int DCS_RUN = 0;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [3:0] DAH_RST = 4'h1;
  // Permitted RAM window and endpoint sizes
  localparam logic [12:0] RAM_LO = 13'h0100;
  localparam logic [12:0] RAM_HI = 13'h08ff;
  localparam logic [2:0] EPS_MAX = 3'h4;
  localparam logic [7:0] EP0_SIZE = 8'h40;
  localparam logic [7:0] EP_DBL_SIZE = 8'h80;
  localparam logic [7:0] EP_SML_SIZE = 8'h08;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RESUME_MS = 13;
  localparam int RESUME_CYCLES = CLK_HZ / 1000 * RESUME_MS;
  // Controller's own register (word index) and its fields
  localparam logic [7:0] IDX_CTRL = 8'hf0;
  localparam int CTRL_EN = 0;
  localparam int CTRL_IE = 1;
  localparam int CTRL_SIE = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: usbd_if.sv
// Register port between the bus controller and the device end.
// Both parties are on the same clock; no signal here crosses domains.
`timescale 1ns/100ps
interface usbd_if;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic usb_en;
  logic cpu_stall;
  logic dma_err;
  logic sec_viol;

  modport dev (
    input reg_addr, reg_wr, reg_rd, reg_wdata, usb_en,
    output reg_rdata, cpu_stall, dma_err, sec_viol
  );
  modport ctl (
    output reg_addr, reg_wr, reg_rd, reg_wdata, usb_en,
    input reg_rdata, cpu_stall, dma_err, sec_viol
  );
endinterface

// file: usbd_dev.sv
// Device end: USB global state, function address, frame number and the
// DMA mover between CPU RAM and the endpoint buffer RAM.
// Assumes the serial engine, RAM and endpoint buffer share aclk, and that
// both memories return read data in the same cycle as their read strobe.
// Function
// - Resume status high for 13 ms emission
// - Remote wake-up only when enable bit set
// - Bus reset clears configured flag
// - Bus reset clears addressed flag
// - Bus reset clears 7-bit function address
// - Frame end set at SOF end, cleared next SOF
// - Frame error follows corruption of last frame
// - Eleven-bit frame number is read-only
// - Registers inaccessible while module disabled
// - N bytes move in N+1 cycles
// - CPU stalled during transfer, uninterruptible
// - Three-bit endpoint select with fixed sizes
// - Zero count or endpoint above 4 violates
// - Good launch clears error; software may clear
// - Bad range or oversize count sets error
// - Error bit raises interrupt when enabled
// - Direction zero endpoint to RAM, one reverse
// - Software sets run; hardware clears at end
// - Twelve-bit base address, high part resets 0x01
// - Window 0x100-0x8ff check, violation, address and count kept
// - Address becomes last touched plus one
// - Seven-bit byte count, resets to zero
// - Byte count kept after transfer
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
module usbd_dev #(
  parameter int RESUME_LEN = usbd_pkg::RESUME_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register port
  usbd_if.dev rp,
  // Serial engine
  input wire logic usb_bus_reset,
  input wire logic sof_detect,
  input wire logic sof_done,
  input wire logic [10:0] sof_frame,
  input wire logic sof_crc_bad,
  input wire logic wake_req,
  output logic resume_signal_active,
  // CPU RAM
  output logic [11:0] ram_addr,
  output logic ram_re,
  output logic ram_we,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Endpoint buffer RAM
  output logic [2:0] ep_sel,
  output logic [6:0] ep_addr,
  output logic ep_re,
  output logic ep_we,
  output logic [7:0] ep_wdata,
  input wire logic [7:0] ep_rdata
);
  logic remote_wakeup_enable_q;
  logic function_configured_flag_q;
  logic function_addressed_flag_q;
  logic [6:0] function_address_field_q;
  logic frame_number_end_q;
  logic frame_number_error_q;
  logic [10:0] frame_number_value_q;
  logic [2:0] dma_endpoint_select_q;
  logic dma_error_flag_q;
  logic dma_direction_q;
  logic dma_run_q;
  logic [11:0] dma_base_address_q;
  logic [6:0] dma_byte_count_q;
  logic [17:0] resume_cnt_q;
  logic [6:0] left_q;
  logic [6:0] idx_q;
  logic rd_q;
  logic [7:0] rdata_q;
  logic sec_viol_q;

  logic wr;
  logic launch;
  logic bad;
  logic [2:0] eps_new;
  logic [7:0] ep_size;
  logic [12:0] base_ext;
  logic [12:0] last_addr;
  logic [7:0] rmux;

  assign wr = rp.reg_wr && rp.usb_en;
  assign eps_new = rp.reg_wdata[usbd_pkg::DCS_EPS +: 3];
  assign launch = wr && rp.reg_addr == usbd_pkg::REG_DCS
    && rp.reg_wdata[usbd_pkg::DCS_RUN] && !dma_run_q;

  // Endpoint sizes by select value
  always_comb begin
    if (eps_new == 3'h0) begin
      ep_size = usbd_pkg::EP0_SIZE;
    end else if (eps_new < usbd_pkg::EPS_MAX) begin
      ep_size = usbd_pkg::EP_DBL_SIZE;
    end else begin
      ep_size = usbd_pkg::EP_SML_SIZE;
    end
  end

  // Launch checks against the new select and current address and count
  assign base_ext = {1'b0, dma_base_address_q};
  assign last_addr = base_ext + {6'h00, dma_byte_count_q} - 13'h0001;
  assign bad = dma_byte_count_q == 7'h00
    || eps_new > usbd_pkg::EPS_MAX
    || base_ext < usbd_pkg::RAM_LO || base_ext > usbd_pkg::RAM_HI
    || last_addr > usbd_pkg::RAM_HI
    || {1'b0, dma_byte_count_q} > ep_size;

  // Global state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_wakeup_enable_q <= 1'b0;
      function_configured_flag_q <= 1'b0;
      function_addressed_flag_q <= 1'b0;
    end else if (usb_bus_reset) begin
      function_configured_flag_q <= 1'b0;
      function_addressed_flag_q <= 1'b0;
    end else if (wr && rp.reg_addr == usbd_pkg::REG_GS) begin
      remote_wakeup_enable_q <= rp.reg_wdata[usbd_pkg::GS_RWE];
      function_configured_flag_q <= rp.reg_wdata[usbd_pkg::GS_CFG];
      function_addressed_flag_q <= rp.reg_wdata[usbd_pkg::GS_ADR];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      function_address_field_q <= 7'h00;
    end else if (usb_bus_reset) begin
      function_address_field_q <= 7'h00;
    end else if (wr && rp.reg_addr == usbd_pkg::REG_FA) begin
      function_address_field_q <= rp.reg_wdata[6:0];
    end
  end

  // Resume emission; a request while already emitting is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_cnt_q <= 18'h00000;
      resume_signal_active <= 1'b0;
    end else if (resume_signal_active) begin
      resume_cnt_q <= resume_cnt_q - 18'h00001;
      if (resume_cnt_q == 18'h00000) begin
        resume_signal_active <= 1'b0;
      end
    end else if (wake_req && remote_wakeup_enable_q) begin
      resume_cnt_q <= 18'(RESUME_LEN - 1);
      resume_signal_active <= 1'b1;
    end
  end

  // Frame number capture; completion wins over a same-cycle SOF detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_number_end_q <= 1'b0;
      frame_number_error_q <= 1'b0;
      frame_number_value_q <= 11'h000;
    end else if (sof_done) begin
      frame_number_end_q <= 1'b1;
      frame_number_error_q <= sof_crc_bad;
      frame_number_value_q <= sof_frame;
    end else if (sof_detect) begin
      frame_number_end_q <= 1'b0;
    end
  end

  // DMA control and status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_endpoint_select_q <= 3'h0;
      dma_direction_q <= 1'b0;
      dma_error_flag_q <= 1'b0;
      sec_viol_q <= 1'b0;
    end else begin
      sec_viol_q <= launch && bad;
      if (wr && rp.reg_addr == usbd_pkg::REG_DCS && !dma_run_q) begin
        dma_endpoint_select_q <= eps_new;
        dma_direction_q <= rp.reg_wdata[usbd_pkg::DCS_DIR];
        if (launch) begin
          dma_error_flag_q <= bad;
        end else begin
          dma_error_flag_q <= rp.reg_wdata[usbd_pkg::DCS_ERR];
        end
      end
    end
  end

  // Address and count; a refused launch leaves both untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_base_address_q <= {usbd_pkg::DAH_RST, 8'h00};
      dma_byte_count_q <= 7'h00;
    end else if (dma_run_q && left_q == 7'h00 && rd_q) begin
      dma_base_address_q <= dma_base_address_q
        + {5'h00, dma_byte_count_q};
    end else if (wr && !dma_run_q) begin
      if (rp.reg_addr == usbd_pkg::REG_DAL) begin
        dma_base_address_q[7:0] <= rp.reg_wdata;
      end
      if (rp.reg_addr == usbd_pkg::REG_DAH) begin
        dma_base_address_q[11:8] <= rp.reg_wdata[3:0];
      end
      if (rp.reg_addr == usbd_pkg::REG_DBC) begin
        dma_byte_count_q <= rp.reg_wdata[6:0];
      end
    end
  end

  // Mover: a read per cycle, its write one cycle later, so N bytes hold
  // the CPU for N+1 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_run_q <= 1'b0;
      left_q <= 7'h00;
      idx_q <= 7'h00;
      rd_q <= 1'b0;
    end else if (launch && !bad) begin
      dma_run_q <= 1'b1;
      left_q <= dma_byte_count_q;
      idx_q <= 7'h00;
      rd_q <= 1'b0;
    end else if (dma_run_q) begin
      rd_q <= left_q != 7'h00;
      if (left_q != 7'h00) begin
        left_q <= left_q - 7'h01;
        idx_q <= idx_q + 7'h01;
      end else if (rd_q) begin
        dma_run_q <= 1'b0;
      end
    end else begin
      rd_q <= 1'b0;
    end
  end

  // Memory strobes: reads use idx_q, writes the index read a cycle ago
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_addr <= 12'h000;
      ram_re <= 1'b0;
      ram_we <= 1'b0;
      ram_wdata <= 8'h00;
      ep_sel <= 3'h0;
      ep_addr <= 7'h00;
      ep_re <= 1'b0;
      ep_we <= 1'b0;
      ep_wdata <= 8'h00;
    end else begin
      ep_sel <= dma_endpoint_select_q;
      ram_re <= dma_run_q && left_q != 7'h00 && dma_direction_q;
      ep_re <= dma_run_q && left_q != 7'h00 && !dma_direction_q;
      ram_we <= rd_q && !dma_direction_q;
      ep_we <= rd_q && dma_direction_q;
      ram_wdata <= ep_rdata;
      ep_wdata <= ram_rdata;
      // The write side trails the read side by one index
      if (dma_run_q) begin
        ram_addr <= dma_base_address_q
          + {5'h00, dma_direction_q ? idx_q : idx_q - 7'h01};
        ep_addr <= dma_direction_q ? idx_q - 7'h01 : idx_q;
      end
    end
  end

  // Register read-back; reserved bits read zero
  always_comb begin
    unique case (rp.reg_addr)
      usbd_pkg::REG_GS: rmux = {4'h0, resume_signal_active,
        remote_wakeup_enable_q, function_configured_flag_q,
        function_addressed_flag_q};
      usbd_pkg::REG_FA: rmux = {1'b0, function_address_field_q};
      usbd_pkg::REG_FNL: rmux = frame_number_value_q[7:0];
      usbd_pkg::REG_FNH: rmux = {3'h0, frame_number_end_q,
        frame_number_error_q, frame_number_value_q[10:8]};
      usbd_pkg::REG_DCS: rmux = {1'b0, dma_endpoint_select_q, 1'b0,
        dma_error_flag_q, dma_direction_q, dma_run_q};
      usbd_pkg::REG_DAL: rmux = dma_base_address_q[7:0];
      usbd_pkg::REG_DAH: rmux = {4'h0, dma_base_address_q[11:8]};
      usbd_pkg::REG_DBC: rmux = {1'b0, dma_byte_count_q};
      default: rmux = usbd_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= usbd_pkg::RST_ZERO;
    end else if (rp.reg_rd) begin
      rdata_q <= rp.usb_en ? rmux : usbd_pkg::RST_ZERO;
    end
  end

  assign rp.reg_rdata = rdata_q;
  assign rp.cpu_stall = dma_run_q;
  assign rp.dma_err = dma_error_flag_q;
  assign rp.sec_viol = sec_viol_q;
endmodule

// file: usbd_ctl.sv
// Controller end: AXI4-Lite slave that turns word accesses into 8-bit
// register port cycles, holds the module enable and interrupt masks.
// Assumes the device end on the same clock; a write answers only after
// any DMA it launched has finished, which is how the CPU is held.
`timescale 1ns/100ps
module usbd_ctl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupts
  output logic usb_irq,
  output logic sec_irq,
  // Register port
  usbd_if.ctl rp
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WISS = 3'b001,
    ST_WSTL = 3'b010,
    ST_BRSP = 3'b011,
    ST_RISS = 3'b100,
    ST_RWT = 3'b101,
    ST_RRSP = 3'b110
  } usbd_st_t;

  usbd_st_t st_q;
  logic [11:0] awaddr_q;
  logic aw_got_q;
  logic [7:0] wdata_q;
  logic wstb_q;
  logic w_got_q;
  logic [11:0] araddr_q;
  logic ar_got_q;
  logic [2:0] ctrl_q;
  logic [7:0] reg_addr_q;
  logic reg_wr_q;
  logic reg_rd_q;
  logic [7:0] reg_wdata_q;

  logic w_dev;
  logic w_ctl;
  logic r_dev;
  logic r_ctl;

  assign w_dev = awaddr_q[11:10] == 2'h3
    && awaddr_q[9:2] >= usbd_pkg::REG_GS
    && awaddr_q[9:2] <= usbd_pkg::REG_DBC;
  assign w_ctl = awaddr_q[11:10] == 2'h0
    && awaddr_q[9:2] == usbd_pkg::IDX_CTRL;
  assign r_dev = araddr_q[11:10] == 2'h3
    && araddr_q[9:2] >= usbd_pkg::REG_GS
    && araddr_q[9:2] <= usbd_pkg::REG_DBC;
  assign r_ctl = araddr_q[11:10] == 2'h0
    && araddr_q[9:2] == usbd_pkg::IDX_CTRL;

  // Channel capture: each ready stays high until its item is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      ar_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 8'h00;
      wstb_q <= 1'b0;
      araddr_q <= 12'h000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstb_q <= s_axi_wstrb[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_got_q <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_got_q <= 1'b1;
        araddr_q <= s_axi_araddr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        ar_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !ar_got_q && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // Transaction sequencer; writes go first when both are waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= usbd_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= usbd_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl_q <= usbd_pkg::CTRL_RST;
      reg_addr_q <= 8'h00;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_wdata_q <= 8'h00;
    end else begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (aw_got_q && w_got_q && !s_axi_bvalid) begin
            s_axi_bresp <= usbd_pkg::RESP_OKAY;
            if (w_ctl) begin
              if (wstb_q) begin
                ctrl_q <= wdata_q[2:0];
              end
              st_q <= ST_BRSP;
            end else if (!w_dev) begin
              s_axi_bresp <= usbd_pkg::RESP_DECERR;
              st_q <= ST_BRSP;
            end else if (!ctrl_q[usbd_pkg::CTRL_EN]) begin
              s_axi_bresp <= usbd_pkg::RESP_SLVERR;
              st_q <= ST_BRSP;
            end else begin
              reg_addr_q <= awaddr_q[9:2];
              reg_wdata_q <= wdata_q;
              reg_wr_q <= wstb_q;
              st_q <= ST_WISS;
            end
          end else if (ar_got_q && !s_axi_rvalid) begin
            s_axi_rresp <= usbd_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (r_ctl) begin
              s_axi_rdata <= {29'h00000000, ctrl_q};
              st_q <= ST_RRSP;
            end else if (!r_dev) begin
              s_axi_rresp <= usbd_pkg::RESP_DECERR;
              st_q <= ST_RRSP;
            end else if (!ctrl_q[usbd_pkg::CTRL_EN]) begin
              s_axi_rresp <= usbd_pkg::RESP_SLVERR;
              st_q <= ST_RRSP;
            end else begin
              reg_addr_q <= araddr_q[9:2];
              reg_rd_q <= 1'b1;
              st_q <= ST_RISS;
            end
          end
        end
        ST_WISS: st_q <= ST_WSTL;
        ST_WSTL: begin
          if (!rp.cpu_stall) begin
            st_q <= ST_BRSP;
          end
        end
        ST_BRSP: begin
          s_axi_bvalid <= 1'b1;
          st_q <= ST_IDLE;
        end
        ST_RISS: st_q <= ST_RWT;
        ST_RWT: begin
          s_axi_rdata <= {24'h000000, rp.reg_rdata};
          st_q <= ST_RRSP;
        end
        ST_RRSP: begin
          s_axi_rvalid <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Interrupt lines; the error bit holds the line until software clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_irq <= 1'b0;
      sec_irq <= 1'b0;
    end else begin
      usb_irq <= rp.dma_err && ctrl_q[usbd_pkg::CTRL_IE];
      sec_irq <= rp.sec_viol && ctrl_q[usbd_pkg::CTRL_SIE];
    end
  end

  assign rp.reg_addr = reg_addr_q;
  assign rp.reg_wr = reg_wr_q;
  assign rp.reg_rd = reg_rd_q;
  assign rp.reg_wdata = reg_wdata_q;
  assign rp.usb_en = ctrl_q[usbd_pkg::CTRL_EN];
endmodule

// file: usbd_sva.sv
// Checker for the register port between bus controller and device end.
// Instantiated beside the interface in the bench; one clock domain.
`timescale 1ns/100ps
module usbd_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic usb_en,
  input wire logic cpu_stall,
  input wire logic dma_err,
  input wire logic sec_viol
);
  logic [7:0] cnt_q;
  logic [7:0] run_q;
  logic launch;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign launch = reg_wr && reg_addr == 8'hea && reg_wdata[0] && !cpu_stall;
  // Shadow of the byte count; the device never changes it by itself
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'hed) cnt_q <= {1'b0, reg_wdata[6:0]};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !cpu_stall) run_q <= 8'h00;
    else run_q <= run_q + 8'h01;
  end
  a_launch_outcome: assert property (launch |=> cpu_stall != dma_err)
    else $error("launch gave neither a run nor an error");
  a_refusal_pulse: assert property (launch ##1 !cpu_stall |-> sec_viol)
    else $error("refused launch gave no violation pulse");
  a_viol_single: assert property (sec_viol |=> !sec_viol)
    else $error("violation pulse longer than one cycle");
  a_run_length: assert property ($fell(cpu_stall) |-> run_q == cnt_q + 8'h01)
    else $error("transfer length is not count plus one");
  a_run_bounded: assert property ($rose(cpu_stall) |-> ##[1:129] !cpu_stall)
    else $error("run bit not cleared in time");
  a_run_no_error: assert property (cpu_stall |-> !dma_err)
    else $error("error set during a transfer");
  a_run_needs_launch: assert property ($rose(cpu_stall) |-> $past(launch))
    else $error("stall without a launch");
  a_cpu_held: assert property (cpu_stall |-> !reg_wr)
    else $error("register write during a transfer");
  a_access_enabled: assert property (reg_wr || reg_rd |-> usb_en)
    else $error("register access while module disabled");
  a_err_by_write: assert property ($changed(dma_err) |-> $past(reg_wr))
    else $error("error bit moved without a write");
  a_addr_reserved: assert property (reg_rd && reg_addr == 8'he7 |=> !reg_rdata[7])
    else $error("reserved address bit reads one");
  c_good_run: cover property (launch ##1 cpu_stall);
  c_refused: cover property (sec_viol);
  c_run_end: cover property ($fell(cpu_stall));
endmodule

// file: tb_top.sv
// Bench joining controller and device end; drives AXI, serial engine
// events and both memories. Memories answer combinationally.
`timescale 1ns/100ps
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, usb_irq, sec_irq;
  logic bus_rst, sof_det, sof_done, crc_bad, wake, resume;
  logic ram_re, ram_we, ep_re, ep_we;
  logic [11:0] awaddr, araddr, ram_addr, base, exp_a;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  logic [10:0] frame;
  logic [7:0] ram_wdata, ep_wdata, d;
  logic [2:0] ep_sel, dma_endpoint_select;
  logic [6:0] ep_addr;
  int fail_count, n_compared, stall_n, wk, sec_n, res_n, rd_n;
  logic [23:0] rows [8] = '{24'he6ff07, 24'he7ff7f, 24'he8ff00, 24'he9ff00,
    24'heaf676, 24'heb3434, 24'hecff0f, 24'hedff7f};
  logic [31:0] bad [6] = '{32'h01000001, 32'h01000151, 32'h00ff0101,
    32'h08ff0201, 32'h01000941, 32'h01004101};
  logic [15:0] good [2] = '{16'h4001, 16'h0843};
  usbd_if rp();
  usbd_dev #(.RESUME_LEN(16)) u_usbd_dev (.aclk(aclk), .aresetn(aresetn),
    .rp(rp), .usb_bus_reset(bus_rst), .sof_detect(sof_det),
    .sof_done(sof_done), .sof_frame(frame), .sof_crc_bad(crc_bad),
    .wake_req(wake), .resume_signal_active(resume), .ram_addr(ram_addr),
    .ram_re(ram_re), .ram_we(ram_we), .ram_wdata(ram_wdata),
    .ram_rdata(ram_addr[7:0] ^ 8'h5a), .ep_sel(ep_sel), .ep_addr(ep_addr),
    .ep_re(ep_re), .ep_we(ep_we), .ep_wdata(ep_wdata),
    .ep_rdata({1'b1, ep_addr}));
  usbd_ctl u_usbd_ctl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .usb_irq(usb_irq), .sec_irq(sec_irq), .rp(rp));
  usbd_sva u_usbd_sva (.aclk(aclk), .aresetn(aresetn),
    .reg_addr(rp.reg_addr), .reg_wr(rp.reg_wr), .reg_rd(rp.reg_rd),
    .reg_wdata(rp.reg_wdata), .reg_rdata(rp.reg_rdata), .usb_en(rp.usb_en),
    .cpu_stall(rp.cpu_stall), .dma_err(rp.dma_err), .sec_viol(rp.sec_viol));
  assign exp_a = base + wk[11:0];
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic hang(input int i);
    if (i >= 400) begin
      fail_count++;
      $display("[FAIL] %0t no bus answer", $time);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    int i;
    // Device registers sit in the top quarter of the map
    awaddr <= {o == 8'hf0 ? 2'b00 : 2'b11, o, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 400; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hang(i);
    bready <= 1'b0;
    r = bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] o);
    int i;
    araddr <= {o == 8'hf0 ? 2'b00 : 2'b11, o, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 400; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hang(i);
    rready <= 1'b0;
    r = rresp;
    d = rdata[7:0];
    @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] o, input logic [7:0] e);
    rd(o);
    chk(d, e);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    tick(5);
    aresetn <= 1'b1;
    tick(1);
  endtask
  task automatic frame_end(input logic [10:0] f, input logic c);
    sof_done <= 1'b1;
    frame <= f;
    crc_bad <= c;
    tick(1);
    sof_done <= 1'b0;
  endtask
  // Byte-by-byte view of both memory ports during a transfer
  always @(posedge aclk) begin
    if (rp.cpu_stall) stall_n++;
    if (sec_irq) sec_n++;
    if (resume) res_n++;
    if (ram_re) rd_n += 256;
    if (ep_re) rd_n++;
    if (ram_we) begin
      chk(ram_wdata, {1'b1, wk[6:0]});
      chk(ram_addr, exp_a);
    end
    if (ep_we) begin
      chk(ep_wdata, exp_a[7:0] ^ 8'h5a);
      chk({ep_sel, ep_addr}, {dma_endpoint_select, wk[6:0]});
    end
    if (ram_we || ep_we) wk++;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {bus_rst, sof_det, sof_done, crc_bad, wake} = '0;
    {awaddr, araddr, wdata, frame, base, dma_endpoint_select} = '0;
    do_reset();
    wr(8'hf0, 8'h07);
    foreach (rows[k]) begin
      wr(rows[k][23:16], rows[k][15:8]);
      rc(rows[k][23:16], rows[k][7:0]);
    end
    frame_end(11'h5a5, 1'b1);
    rc(8'he8, 8'ha5);
    rc(8'he9, 8'h1d);
    sof_det <= 1'b1;
    tick(1);
    sof_det <= 1'b0;
    rc(8'he9, 8'h0d);
    frame_end(11'h003, 1'b0);
    rc(8'he9, 8'h10);
    bus_rst <= 1'b1;
    tick(1);
    bus_rst <= 1'b0;
    rc(8'he6, 8'h04);
    rc(8'he7, 8'h00);
    res_n = 0;
    for (int k = 0; k < 2; k++) begin
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
      tick(30);
      chk(res_n[11:0], 12'd16);
      wr(8'he6, 8'h00);
    end
    foreach (bad[k]) begin
      wr(8'hec, bad[k][31:24]);
      wr(8'heb, bad[k][23:16]);
      wr(8'hed, bad[k][15:8]);
      stall_n = 0;
      sec_n = 0;
      wr(8'hea, bad[k][7:0]);
      tick(3);
      chk({stall_n[7:0], sec_n[3:0]}, 12'h001);
      chk(usb_irq, 1'b1);
      rc(8'hea, (bad[k][7:0] & 8'h72) | 8'h04);
      rc(8'heb, bad[k][23:16]);
      rc(8'hed, bad[k][15:8]);
    end
    wr(8'hec, 8'h01);
    wr(8'heb, 8'h00);
    base = 12'h100;
    foreach (good[k]) begin
      wr(8'hed, good[k][15:8]);
      dma_endpoint_select = good[k][6:4];
      wk = 0;
      rd_n = 0;
      stall_n = 0;
      wr(8'hea, good[k][7:0]);
      chk(stall_n[11:0], good[k][15:8] + 12'h1);
      chk(wk[11:0], good[k][15:8]);
      chk(rd_n[11:0], good[k][1] ? {good[k][11:8], 8'h00}
        : {4'h0, good[k][15:8]});
      rc(8'hea, good[k][7:0] & 8'h72);
      base = base + good[k][15:8];
      rc(8'heb, base[7:0]);
      rc(8'hed, good[k][15:8]);
    end
    do_reset();
    rd(8'hec);
    chk(r, usbd_pkg::RESP_SLVERR);
    wr(8'he6, 8'hff);
    chk(r, usbd_pkg::RESP_SLVERR);
    rd(8'h00);
    chk(r, usbd_pkg::RESP_DECERR);
    wr(8'hf0, 8'h07);
    rc(8'hec, 8'h01);
    rc(8'hed, 8'h00);
    rc(8'he6, 8'h00);
    give_verdict();
  end
endmodule
